// >>> conv_ctrl_pkg.sv
// Register map, field layout, timing counts and carriers of the converter control block
package conv_ctrl_pkg;

   // Register offsets on the plain register port
   localparam logic [2:0] OFS_CTRL_A     = 3'h0;
   localparam logic [2:0] OFS_CTRL_B     = 3'h1;
   localparam logic [2:0] OFS_INPUT_SEL  = 3'h2;
   localparam logic [2:0] OFS_RESULT_LOW = 3'h3;
   localparam logic [2:0] OFS_RESULT_HI  = 3'h4;

   // Control/status A field positions
   localparam int BIT_ENABLE    = 7;
   localparam int BIT_START     = 6;
   localparam int BIT_AUTO_TRIG = 5;
   localparam int BIT_DONE_FLAG = 4;
   localparam int BIT_IRQ_EN    = 3;
   localparam int BIT_PRESC_HI  = 2;

   // Control/status B and input select field positions
   localparam int BIT_TRIG_SRC_HI = 2;
   localparam int BIT_REF_HI      = 7;
   localparam int BIT_REF_LO      = 6;
   localparam int BIT_LEFT_ALIGN  = 5;
   localparam int BIT_CHAN_HI     = 3;

   // Reset values
   localparam logic [7:0] RST_CTRL_A    = 8'h00;
   localparam logic [7:0] RST_CTRL_B    = 8'h00;
   localparam logic [7:0] RST_INPUT_SEL = 8'h00;

   // Trigger source that restarts on the block's own completion
   localparam logic [2:0] TRIG_SRC_SELF = 3'h0;

   // Conversion lengths in converter clock cycles
   localparam logic [4:0] NORMAL_CYCLES = 5'h0d;
   localparam logic [4:0] FIRST_CYCLES  = 5'h19;

   // Selection applied to the analog core
   typedef struct packed {
      logic       enable;
      logic [1:0] reference_select;
      logic [3:0] channel_select;
   } core_ctrl_t;

   // Result returned by the analog core
   typedef struct packed {
      logic       done;
      logic [9:0] value;
   } core_result_t;

endpackage : conv_ctrl_pkg

// >>> sar_adc_conversion_control.sv
// Conversion control for a 10-bit successive-approximation converter
`timescale 1ns/1ps

// Function
// - Each result is 10 bits in low and high registers, right aligned by default.
// - Left-align bit places the top eight result bits in the high register.
// - Reference and channel selections reach the core only while enabled.
// - Reading low locks results until high is read; locked completions are lost.
// - Completion flag is still set when a locked result is lost.
// - Writing start begins one conversion; bit stays set until completion.
// - Channel changes during a conversion apply only after it completes.
// - Auto-trigger enable lets the selected trigger source start conversions.
// - A trigger rising edge resets the prescaler and starts a conversion.
// - Only rising edges start; high levels and edges while busy are ignored.
// - The completion flag is set even when masked; a set flag does not block retriggering.
// - Self trigger converts continuously; software starts the first one.
// - Start bit still works under auto-trigger and reads one while busy.
// - Channel select picks eight pins, ground or the bandgap reference.
// - A dedicated interrupt request can be raised on completion.
// - Normal conversions take 13 converter clocks, the first after enable 25.
// - A start-bit conversion begins at the next converter clock rising edge.
// - Prescaler counts while enabled and is held in reset while disabled.
// - Completion writes results unless locked, sets the flag and clears start in single mode.
module sar_adc_conversion_control #(
   parameter int TRIG_WIDTH = 7
) (
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       reset_n,
   // Register port
   input  wire logic [2:0]                 address,
   input  wire logic [7:0]                 write_data,
   input  wire logic                       write_strobe,
   input  wire logic                       read_strobe,
   output logic      [7:0]                 read_data,
   // System side
   input  wire logic                       converter_power_reduction,
   input  wire logic [TRIG_WIDTH:1]        trigger_in,
   output logic                            irq,
   // Analog core
   output logic                            core_start,
   output conv_ctrl_pkg::core_ctrl_t       core_ctrl,
   input  wire conv_ctrl_pkg::core_result_t core_result
);
   import conv_ctrl_pkg::*;

   typedef enum logic [1:0] {S_IDLE, S_CONV, S_WAIT_CORE} conv_state_t;

   conv_state_t  state_reg,        state_next;
   logic [7:0]   ctrl_a_reg,       ctrl_a_next;
   logic [2:0]   trig_src_reg,     trig_src_next;
   logic [7:0]   input_sel_reg,    input_sel_next;
   logic [9:0]   result_reg,       result_next;
   logic         lock_reg,         lock_next;
   logic         first_reg,        first_next;
   logic         flag_reg,         flag_next;
   logic         start_reg,        start_next;
   logic         trig_prev_reg,    trig_prev_next;
   logic [7:0]   presc_reg,        presc_next;
   logic [4:0]   cycle_reg,        cycle_next;
   logic [7:0]   rdata_reg,        rdata_next;
   logic         irq_reg,          irq_next;
   logic         core_start_reg,   core_start_next;
   core_ctrl_t   core_ctrl_reg,    core_ctrl_next;
   logic [2:0]   done_sync_reg;

   logic         enabled;
   logic         auto_trig;
   logic         self_trig;
   logic         trig_level;
   logic         trig_edge;
   logic         tick;
   logic [7:0]   presc_mask;
   logic [4:0]   conv_len;
   logic         core_done;
   logic         done_evt;
   logic         wr_a;
   logic         rd_low;
   logic         rd_high;
   logic [7:0]   low_view;
   logic [7:0]   high_view;

   // Core done pin passes three flops
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         done_sync_reg <= 3'h0;
      end else begin
         done_sync_reg <= {done_sync_reg[1:0], core_result.done};
      end
   end

   always_comb begin
      enabled    = ctrl_a_reg[BIT_ENABLE] && !converter_power_reduction;
      auto_trig  = ctrl_a_reg[BIT_AUTO_TRIG];
      self_trig  = auto_trig && (trig_src_reg == TRIG_SRC_SELF);
      trig_level = 1'b0;
      if (trig_src_reg != TRIG_SRC_SELF) begin
         trig_level = trigger_in[trig_src_reg];
      end
      trig_edge  = trig_level && !trig_prev_reg;
      presc_mask = 8'((16'h0002 << ctrl_a_reg[BIT_PRESC_HI:0]) - 16'h0001);
      tick       = enabled && ((presc_reg & presc_mask) == presc_mask);
      conv_len   = first_reg ? FIRST_CYCLES : NORMAL_CYCLES;
      core_done  = done_sync_reg[1] && done_sync_reg[2];
      done_evt   = enabled && core_done &&
                   (((state_reg == S_CONV) && tick && (cycle_reg == conv_len - 5'h01)) ||
                    (state_reg == S_WAIT_CORE));
      wr_a       = write_strobe && (address == OFS_CTRL_A);
      rd_low     = read_strobe && (address == OFS_RESULT_LOW);
      rd_high    = read_strobe && (address == OFS_RESULT_HI);
      low_view   = result_reg[7:0];
      high_view  = {6'h00, result_reg[9:8]};
      if (input_sel_reg[BIT_LEFT_ALIGN]) begin
         low_view  = {result_reg[1:0], 6'h00};
         high_view = result_reg[9:2];
      end
   end

   always_comb begin
      state_next      = state_reg;
      ctrl_a_next     = ctrl_a_reg;
      trig_src_next   = trig_src_reg;
      input_sel_next  = input_sel_reg;
      result_next     = result_reg;
      lock_next       = lock_reg;
      first_next      = first_reg;
      flag_next       = flag_reg;
      start_next      = start_reg;
      trig_prev_next  = trig_level;
      presc_next      = presc_reg + 8'h01;
      cycle_next      = cycle_reg;
      core_start_next = 1'b0;
      core_ctrl_next  = core_ctrl_reg;
      rdata_next      = 8'h00;

      // Register writes
      if (wr_a) begin
         ctrl_a_next = write_data & ~(8'h01 << BIT_DONE_FLAG) & ~(8'h01 << BIT_START);
         ctrl_a_next[BIT_DONE_FLAG] = 1'b0;
         if (write_data[BIT_START]) begin
            start_next = 1'b1;
         end
         // Software clears the flag by writing one
         if (write_data[BIT_DONE_FLAG]) begin
            flag_next = 1'b0;
         end
         if (write_data[BIT_ENABLE] && !ctrl_a_reg[BIT_ENABLE]) begin
            first_next = 1'b1;
         end
      end
      if (write_strobe && (address == OFS_CTRL_B)) begin
         trig_src_next = write_data[BIT_TRIG_SRC_HI:0];
      end
      if (write_strobe && (address == OFS_INPUT_SEL)) begin
         input_sel_next = write_data;
      end

      // Low read locks, high read unlocks
      if (rd_low) begin
         lock_next = 1'b1;
      end
      if (rd_high) begin
         lock_next = 1'b0;
      end

      if (!enabled) begin
         presc_next = 8'h00;
         state_next = S_IDLE;
         cycle_next = 5'h00;
         start_next = 1'b0;
      end else begin
         unique case (state_reg)
            S_IDLE: begin
               // Trigger edge resets prescaler and starts
               if (auto_trig && !self_trig && trig_edge) begin
                  presc_next      = 8'h00;
                  state_next      = S_CONV;
                  cycle_next      = 5'h00;
                  core_start_next = 1'b1;
               // Start bit waits for a converter clock edge
               end else if (start_reg && tick) begin
                  state_next      = S_CONV;
                  cycle_next      = 5'h00;
                  core_start_next = 1'b1;
               end
            end
            S_CONV: begin
               if (tick) begin
                  cycle_next = cycle_reg + 5'h01;
                  if (cycle_reg == conv_len - 5'h01) begin
                     state_next = S_WAIT_CORE;
                  end
               end
            end
            S_WAIT_CORE: begin
            end
         endcase
      end

      if (done_evt) begin
         if (!lock_reg) begin
            result_next = core_result.value;
         end
         first_next = 1'b0;
         state_next = S_IDLE;
         cycle_next = 5'h00;
         if (self_trig) begin
            state_next      = S_CONV;
            core_start_next = 1'b1;
         end else begin
            start_next = 1'b0;
         end
      end
      if (done_evt) begin
         flag_next = 1'b1;
      end

      core_ctrl_next.enable = enabled;
      if (enabled && ((state_reg == S_IDLE) || done_evt)) begin
         core_ctrl_next.reference_select = input_sel_reg[BIT_REF_HI:BIT_REF_LO];
         // Pins 0-7, bandgap and ground codes pass as written
         core_ctrl_next.channel_select   = input_sel_reg[BIT_CHAN_HI:0];
      end

      // Read data, one cycle later
      if (read_strobe) begin
         unique case (address)
            OFS_CTRL_A: begin
               rdata_next = ctrl_a_reg;
               rdata_next[BIT_DONE_FLAG] = flag_reg;
               rdata_next[BIT_START] = start_reg || (state_reg != S_IDLE);
            end
            OFS_CTRL_B:     rdata_next = {5'h00, trig_src_reg};
            OFS_INPUT_SEL:  rdata_next = input_sel_reg;
            OFS_RESULT_LOW: rdata_next = low_view;
            OFS_RESULT_HI:  rdata_next = high_view;
            default:        rdata_next = 8'h00;
         endcase
      end

      irq_next = flag_next && ctrl_a_next[BIT_IRQ_EN];
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_reg      <= S_IDLE;
         ctrl_a_reg     <= RST_CTRL_A;
         trig_src_reg   <= RST_CTRL_B[BIT_TRIG_SRC_HI:0];
         input_sel_reg  <= RST_INPUT_SEL;
         result_reg     <= 10'h000;
         lock_reg       <= 1'b0;
         first_reg      <= 1'b0;
         flag_reg       <= 1'b0;
         start_reg      <= 1'b0;
         trig_prev_reg  <= 1'b0;
         presc_reg      <= 8'h00;
         cycle_reg      <= 5'h00;
         rdata_reg      <= 8'h00;
         irq_reg        <= 1'b0;
         core_start_reg <= 1'b0;
         core_ctrl_reg  <= '0;
      end else begin
         state_reg      <= state_next;
         ctrl_a_reg     <= ctrl_a_next;
         trig_src_reg   <= trig_src_next;
         input_sel_reg  <= input_sel_next;
         result_reg     <= result_next;
         lock_reg       <= lock_next;
         first_reg      <= first_next;
         flag_reg       <= flag_next;
         start_reg      <= start_next;
         trig_prev_reg  <= trig_prev_next;
         presc_reg      <= presc_next;
         cycle_reg      <= cycle_next;
         rdata_reg      <= rdata_next;
         irq_reg        <= irq_next;
         core_start_reg <= core_start_next;
         core_ctrl_reg  <= core_ctrl_next;
      end
   end

   assign read_data  = rdata_reg;
   assign irq        = irq_reg;
   assign core_start = core_start_reg;
   assign core_ctrl  = core_ctrl_reg;
   // Checks
   property p_single_clears;
      @(posedge clk) disable iff (!reset_n)
         (done_evt && !self_trig) |=> (!start_reg && state_reg == S_IDLE);
   endproperty
   a_single_clears: assert property (p_single_clears) else $error("start not cleared");

   property p_lock_holds;
      @(posedge clk) disable iff (!reset_n)
         (done_evt && lock_reg) |=> $stable(result_reg);
   endproperty
   a_lock_holds: assert property (p_lock_holds) else $error("locked result changed");

   property p_flag_on_done;
      @(posedge clk) disable iff (!reset_n)
         done_evt |=> flag_reg;
   endproperty
   a_flag_on_done: assert property (p_flag_on_done) else $error("flag not set");

   property p_left_high;
      @(posedge clk) disable iff (!reset_n)
         (read_strobe && address == OFS_RESULT_HI && input_sel_reg[BIT_LEFT_ALIGN]
          && !write_strobe) |=> (read_data == $past(result_reg[9:2]));
   endproperty
   a_left_high: assert property (p_left_high) else $error("left aligned read wrong");

   property p_chan_locked;
      @(posedge clk) disable iff (!reset_n)
         (state_reg != S_IDLE && !done_evt) |=> $stable(core_ctrl_reg.channel_select);
   endproperty
   a_chan_locked: assert property (p_chan_locked) else $error("channel moved mid conversion");

   property p_off_holds;
      @(posedge clk) disable iff (!reset_n)
         !enabled |=> ($stable(core_ctrl_reg.channel_select) && presc_reg == 8'h00);
   endproperty
   a_off_holds: assert property (p_off_holds) else $error("disabled converter moved");

   property p_busy_no_start;
      @(posedge clk) disable iff (!reset_n)
         (state_reg == S_CONV && !done_evt) |=> !core_start_reg;
   endproperty
   a_busy_no_start: assert property (p_busy_no_start) else $error("start while busy");

   property p_busy_reads_one;
      @(posedge clk) disable iff (!reset_n)
         (read_strobe && address == OFS_CTRL_A && state_reg != S_IDLE)
            |=> read_data[BIT_START];
   endproperty
   a_busy_reads_one: assert property (p_busy_reads_one) else $error("start reads zero");

   property p_trig_start;
      @(posedge clk) disable iff (!reset_n)
         (enabled && state_reg == S_IDLE && auto_trig && !self_trig && trig_edge)
            |=> (core_start_reg && presc_reg == 8'h00);
   endproperty
   a_trig_start: assert property (p_trig_start) else $error("trigger ignored");

   c_single:  cover property (@(posedge clk) disable iff (!reset_n) done_evt && !self_trig);
   c_lost:    cover property (@(posedge clk) disable iff (!reset_n) done_evt && lock_reg);
   c_free:    cover property (@(posedge clk) disable iff (!reset_n) done_evt && self_trig);
   c_trigger: cover property (@(posedge clk) disable iff (!reset_n)
                              state_reg == S_IDLE && auto_trig && trig_edge && enabled);

endmodule : sar_adc_conversion_control

// >>> adc_core_model.sv
// Behavioural analog core: holds the input on start and reports done after a delay
`timescale 1ns/1ps
module adc_core_model (
   // Clock
   input  wire logic                        clk,
   // Control from the block
   input  wire logic                        core_start,
   input  wire conv_ctrl_pkg::core_ctrl_t   core_ctrl,
   // Stimulus from the bench
   input  wire logic [9:0]                  level,
   input  wire logic [7:0]                  delay,
   // Result to the block
   output conv_ctrl_pkg::core_result_t      core_result
);
   import conv_ctrl_pkg::*;
   logic [9:0] held_reg = 10'h000;
   logic [7:0] cnt_reg  = 8'h00;
   logic       busy_reg = 1'b0;
   logic       done_reg = 1'b0;
   always @(posedge clk) begin
      if (core_start) begin
         held_reg <= level ^ {core_ctrl.channel_select, 6'h00};
         cnt_reg <= 8'h00;
         busy_reg <= 1'b1;
         done_reg <= 1'b0;
      end else if (busy_reg && cnt_reg != delay) begin
         cnt_reg <= cnt_reg + 8'h01;
      end else if (busy_reg) begin
         busy_reg <= 1'b0;
         done_reg <= 1'b1;
      end
   end
   // Value is only held while done is high
   assign core_result = {done_reg, done_reg ? held_reg : ~held_reg};
endmodule : adc_core_model

// >>> tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_top;
   import conv_ctrl_pkg::*;
   logic         clk;
   logic         reset_n;
   logic [2:0]   address;
   logic [7:0]   write_data;
   logic         write_strobe;
   logic         read_strobe;
   logic [7:0]   read_data;
   logic         power_reduction;
   logic [7:1]   trigger_in;
   logic         irq;
   logic         core_start;
   core_ctrl_t   core_ctrl;
   core_result_t core_result;
   logic [9:0]   level;
   logic [7:0]   delay;
   logic [7:0]   q;
   int           miscompares = 0;
   int           n_tests = 0;
   int           n_starts = 0;
   int           cyc = 0;
   int           n;
   int           k;

   sar_adc_conversion_control u_sar_adc_conversion_control (
      .clk(clk), .reset_n(reset_n), .address(address), .write_data(write_data),
      .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
      .converter_power_reduction(power_reduction), .trigger_in(trigger_in), .irq(irq),
      .core_start(core_start), .core_ctrl(core_ctrl), .core_result(core_result));
   adc_core_model u_adc_core_model (
      .clk(clk), .core_start(core_start), .core_ctrl(core_ctrl), .level(level),
      .delay(delay), .core_result(core_result));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (core_start === 1'b1)
         n_starts <= n_starts + 1;
   end

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      address <= a;
      write_data <= d;
      write_strobe <= 1'b1;
      @(posedge clk);
      write_strobe <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a);
      @(posedge clk);
      address <= a;
      read_strobe <= 1'b1;
      @(posedge clk);
      read_strobe <= 1'b0;
      #1;
      q = read_data;
   endtask : rd
   task automatic wt(input bit on_irq, input int lim);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while ((on_irq ? irq : core_start) !== 1'b1 && n < lim);
      if ((on_irq ? irq : core_start) !== 1'b1) begin
         miscompares++;
         $display("mismatch wait_limit expected %0d seen %0d", lim, n);
         end_sim();
      end
   endtask : wt
   task automatic conv;
      wr(OFS_CTRL_A, 8'hc8);
      wt(1'b0, 4);
      k = cyc;
      wt(1'b1, 300);
      n = cyc - k;
   endtask : conv
   task automatic rdres(input logic [7:0] lo, input logic [7:0] hi);
      rd(OFS_RESULT_LOW);
      chk("result_low", q, lo);
      rd(OFS_RESULT_HI);
      chk("result_high", q, hi);
   endtask : rdres

   task automatic t_reset;
      rd(OFS_CTRL_A);
      chk("ctrl_a", q, RST_CTRL_A);
      rd(OFS_CTRL_B);
      chk("ctrl_b", q, RST_CTRL_B);
      rd(OFS_INPUT_SEL);
      chk("input_sel", q, RST_INPUT_SEL);
      wr(3'h6, 8'hff);
      rd(3'h6);
      chk("unmapped", q, 8'h00);
      wr(OFS_INPUT_SEL, 8'h45);
      wr(OFS_CTRL_A, 8'h80);
      repeat (3) @(posedge clk);
      chk("sel_held", core_ctrl, 7'h00);
      power_reduction <= 1'b0;
      repeat (3) @(posedge clk);
      chk("sel_applied", core_ctrl, 7'h55);
      wr(OFS_INPUT_SEL, 8'h00);
      $display("test reset done");
   endtask : t_reset
   task automatic t_single;
      level <= 10'h2a5;
      wr(OFS_CTRL_A, 8'hc8);
      wt(1'b0, 4);
      chk("start_pulse", core_start, 1'b1);
      k = cyc;
      rd(OFS_CTRL_A);
      chk("busy_bit", q[6], 1'b1);
      wt(1'b1, 300);
      chk("first_len", (cyc - k >= 50) && (cyc - k <= 58), 1'b1);
      rd(OFS_CTRL_A);
      chk("start_clear", q & 8'h50, 8'h10);
      rdres(8'ha5, 8'h02);
      wr(OFS_CTRL_A, 8'h98);
      #1;
      chk("irq_clear", irq, 1'b0);
      conv();
      chk("normal_len", (n >= 26) && (n <= 34), 1'b1);
      wr(OFS_CTRL_A, 8'h98);
      delay <= 8'd60;
      conv();
      chk("slow_core", n >= 60, 1'b1);
      delay <= 8'd2;
      wr(OFS_CTRL_A, 8'h98);
      $display("test single done");
   endtask : t_single
   task automatic t_lock;
      rd(OFS_RESULT_LOW);
      chk("locked_low", q, 8'ha5);
      level <= 10'h15a;
      conv();
      chk("irq_lost", irq, 1'b1);
      wr(OFS_CTRL_A, 8'h98);
      rd(OFS_RESULT_HI);
      chk("locked_high", q, 8'h02);
      rdres(8'ha5, 8'h02);
      conv();
      wr(OFS_CTRL_A, 8'h98);
      rdres(8'h5a, 8'h01);
      wr(OFS_INPUT_SEL, 8'h20);
      rdres(8'h80, 8'h56);
      wr(OFS_INPUT_SEL, 8'h00);
      $display("test lock done");
   endtask : t_lock
   task automatic t_chan;
      level <= 10'h000;
      wr(OFS_INPUT_SEL, 8'h45);
      wr(OFS_CTRL_A, 8'hc9);
      wt(1'b0, 4);
      k = cyc;
      wr(OFS_INPUT_SEL, 8'h8e);
      repeat (2) @(posedge clk);
      chk("sel_frozen", core_ctrl, 7'h55);
      wt(1'b1, 300);
      chk("div4_len", 16'(cyc - k), 16'(NORMAL_CYCLES * 4));
      wr(OFS_CTRL_A, 8'h98);
      chk("sel_new", core_ctrl, 7'h6e);
      rdres(8'h40, 8'h01);
      wr(OFS_INPUT_SEL, 8'h00);
      $display("test channel done");
   endtask : t_chan
   task automatic t_trig;
      for (int s = 1; s <= 7; s++) begin
         wr(OFS_CTRL_B, 8'(s));
         wr(OFS_CTRL_A, 8'ha8);
         k = n_starts;
         trigger_in <= ~(7'h01 << (s - 1));
         repeat (4) @(posedge clk);
         chk("other_source", 16'(n_starts - k), 16'h0000);
         trigger_in <= 7'h7f;
         wt(1'b0, 3);
         repeat (2) @(posedge clk);
         trigger_in <= 7'h00;
         @(posedge clk);
         trigger_in <= 7'h7f;
         wt(1'b1, 300);
         wr(OFS_CTRL_A, 8'hb8);
         repeat (40) @(posedge clk);
         chk("edge_only", 16'(n_starts - k), 16'h0001);
         trigger_in <= 7'h00;
      end
      wr(OFS_CTRL_A, 8'he8);
      wt(1'b0, 4);
      rd(OFS_CTRL_A);
      chk("busy_auto", q[6], 1'b1);
      wt(1'b1, 300);
      wr(OFS_CTRL_A, 8'hb8);
      $display("test trigger done");
   endtask : t_trig
   task automatic t_free;
      wr(OFS_CTRL_B, {5'h00, TRIG_SRC_SELF});
      k = n_starts;
      wr(OFS_CTRL_A, 8'he8);
      repeat (120) @(posedge clk);
      chk("free_run", n_starts - k >= 3, 1'b1);
      rd(OFS_CTRL_A);
      chk("free_bits", q & 8'h50, 8'h50);
      wr(OFS_CTRL_A, 8'h00);
      repeat (3) @(posedge clk);
      chk("disabled", core_ctrl.enable, 1'b0);
      $display("test free run done");
   endtask : t_free

   initial begin
      reset_n = 1'b0;
      address = 3'h0;
      write_data = 8'h00;
      write_strobe = 1'b0;
      read_strobe = 1'b0;
      power_reduction = 1'b1;
      trigger_in = 7'h00;
      level = 10'h000;
      delay = 8'd2;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_single();
      t_lock();
      t_chan();
      t_trig();
      t_free();
      end_sim();
   end
endmodule : tb_top
